// [rtl/usb_aux_status_consts.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 125 MHz system clock
// Notes: Shared by the status block and its controller
`ifndef USB_AUX_STATUS_CONSTS_SVH
`define USB_AUX_STATUS_CONSTS_SVH

`define ADDR_BUS_STATUS_CONTROL      8'h1A
`define ADDR_ENDPOINT_FLAGS_MODE     8'h1B
`define ADDR_CLOCK_CONTROL           8'h1C

`define BIT_BUS_IDLE_FLAG            0
`define BIT_REMOTE_WAKE_COMMAND      1
`define BIT_BUS_RESET_FLAG           2
`define BIT_WAKE_SEEN_FLAG           3
`define BIT_AUX_DATA_PIN_IN          4
`define BIT_AUX_CLOCK_PIN_IN         5
`define BIT_AUX_DATA_PIN_OUT         6
`define BIT_AUX_CLOCK_PIN_OUT        7

`define BIT_SELECT_AUX_BUS           4
`define BIT_SELECT_USB_BUS           5
`define BIT_CONVERTER_REFERENCE      6
`define BIT_EMULATOR_FIFO_DIR        7

`define BIT_BUS_CLOCK_ENABLE         3
`define BIT_DEEP_HALT_POWER          4

`define RST_AUX_PIN_OUT              1'b1
`define RST_SELECT_AUX_BUS           1'b0
`define RST_SELECT_USB_BUS           1'b0
`define RST_CONVERTER_REFERENCE      1'b1
`define RST_EMULATOR_FIFO_DIR        1'b0
`define RST_CLOCK_CONTROL            8'h00
`define CLOCK_CONTROL_ARMED          8'h08

`define CLK_PERIOD_NS                8
`define REMOTE_WAKE_HOLD_NS          2000
`define REMOTE_WAKE_HOLD_CYCLES      ((`REMOTE_WAKE_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_SEEN_HOLD_MS            20
`define WAKE_SEEN_HOLD_CYCLES        ((`WAKE_SEEN_HOLD_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define CTL_ADDR_COMMAND             4'h0
`define CTL_ADDR_TARGET              4'h1
`define CTL_ADDR_DATA                4'h2
`define CTL_ADDR_STATUS              4'h3
`define CMD_RAW_WRITE                0
`define CMD_RAW_READ                 1
`define CMD_ARM_DETECT               2
`define CMD_REMOTE_WAKE              3
`define CMD_CLEAR_ENDPOINT           4
`define CMD_EP_LSB                   5
`define STAT_BUSY                    0
`define STAT_WAKE_RECORDED           1
`define STAT_IRQ_SEEN                2

`endif

// [rtl/usb_aux_status_pkg.sv]
// Purpose: Types shared by both ends
// Assumes: Constants come from the consts header
// Notes: Controller sequencer states
package usb_aux_status_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WRITE,
        ST_READ,
        ST_READ_WAIT,
        ST_EP_WRITE,
        ST_WAKE_HOLD,
        ST_WAKE_RELEASE
    } ctl_state_t;
endpackage

// [rtl/usb_aux_status_if.sv]
// Purpose: Register port between status block and its controller
// Assumes: One clock, read data one cycle after read strobe
// Notes: Interrupt pulses flow back to the controller
`timescale 1ns/1ns
interface usb_aux_status_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       usb_irq;
    logic       wake_irq;

    modport dev (input addr, input wdata, input wr, input rd,
                 output rdata, output usb_irq, output wake_irq);
    modport ctl (output addr, output wdata, output wr, output rd,
                 input rdata, input usb_irq, input wake_irq);
endinterface

// [rtl/usb_aux_status_dev.sv]
// Purpose: Bus status, endpoint flags and mode select registers
// Assumes: Engine event inputs are on i_clk_sys; pin inputs are not
// Notes: Aux pins are open drain, driven low only in aux mode
`timescale 1ns/1ns
`include "usb_aux_status_consts.svh"
module usb_aux_status_dev
    import usb_aux_status_pkg::*;
#(
    parameter int WAKE_HOLD_CYCLES = `WAKE_SEEN_HOLD_CYCLES
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    usb_aux_status_if.dev   bus,
    input  wire logic       i_sie_suspend,
    input  wire logic       i_sie_bus_reset,
    input  wire logic       i_sie_resume,
    input  wire logic [3:0] i_ep_access,
    input  wire logic       i_aux_data_pin,
    input  wire logic       i_aux_clock_pin,
    output logic            o_aux_data_pin,
    output logic            o_aux_data_oe,
    output logic            o_aux_clock_pin,
    output logic            o_aux_clock_oe,
    output logic            o_remote_wake,
    output logic            o_select_aux_bus,
    output logic            o_select_usb_bus,
    output logic            o_converter_reference,
    output logic            o_emulator_fifo_dir,
    output logic            o_bus_clock_enable,
    output logic            o_deep_halt
);
    logic [1:0]  data_sync;
    logic [1:0]  clock_sync;
    logic        bus_idle_flag;
    logic        bus_reset_flag;
    logic        wake_seen_flag;
    logic [31:0] wake_count;
    logic        aux_data_pin_out;
    logic        aux_clock_pin_out;
    logic [3:0]  endpoint_flags;
    logic [7:0]  clock_control;
    logic        wr_status;
    logic        wr_mode;
    logic        wr_clock;
    logic [3:0]  ep_clear;
    logic        idle_change;
    logic        reset_rise;
    logic        wake_set;
    logic [7:0]  next_rdata;

    assign wr_status = bus.wr && (bus.addr == `ADDR_BUS_STATUS_CONTROL);
    assign wr_mode   = bus.wr && (bus.addr == `ADDR_ENDPOINT_FLAGS_MODE);
    assign wr_clock  = bus.wr && (bus.addr == `ADDR_CLOCK_CONTROL);

    // Pins come from outside the clock domain
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            data_sync  <= 2'h3;
            clock_sync <= 2'h3;
        end else begin
            data_sync  <= {data_sync[0], i_aux_data_pin};
            clock_sync <= {clock_sync[0], i_aux_clock_pin};
        end
    end

    assign idle_change = i_sie_suspend != bus_idle_flag;
    assign reset_rise  = i_sie_bus_reset && !bus_reset_flag;
    // Resume counts only while idle; leaving suspend clears the flag only once the hold count has run out
    assign wake_set    = i_sie_resume && bus_idle_flag;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus_idle_flag  <= 1'b0;
            bus_reset_flag <= 1'b0;
        end else begin
            bus_idle_flag  <= i_sie_suspend;
            bus_reset_flag <= i_sie_bus_reset;
        end
    end

    // Wake seen lingers until the hold count started at resume runs out, even after idle drops
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wake_seen_flag <= 1'b0;
            wake_count     <= 32'h0;
        end else if (wake_set) begin
            wake_seen_flag <= 1'b1;
            wake_count     <= 32'(WAKE_HOLD_CYCLES);
        end else begin
            if (wake_count != 32'h0) begin
                wake_count <= wake_count - 32'h1;
            end
            if (wake_count == 32'h0 && !bus_idle_flag) begin
                wake_seen_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_remote_wake     <= 1'b0;
            aux_data_pin_out  <= `RST_AUX_PIN_OUT;
            aux_clock_pin_out <= `RST_AUX_PIN_OUT;
        end else if (wr_status) begin
            o_remote_wake     <= bus.wdata[`BIT_REMOTE_WAKE_COMMAND];
            aux_data_pin_out  <= bus.wdata[`BIT_AUX_DATA_PIN_OUT];
            aux_clock_pin_out <= bus.wdata[`BIT_AUX_CLOCK_PIN_OUT];
        end
    end

    // Writing one leaves a flag alone; a new access beats a clear
    assign ep_clear = wr_mode ? ~bus.wdata[3:0] : 4'h0;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            endpoint_flags <= 4'h0;
        end else begin
            endpoint_flags <= (endpoint_flags & ~ep_clear) | i_ep_access;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_select_aux_bus      <= `RST_SELECT_AUX_BUS;
            o_select_usb_bus      <= `RST_SELECT_USB_BUS;
            o_converter_reference <= `RST_CONVERTER_REFERENCE;
            o_emulator_fifo_dir   <= `RST_EMULATOR_FIFO_DIR;
        end else if (wr_mode) begin
            o_select_aux_bus      <= bus.wdata[`BIT_SELECT_AUX_BUS];
            o_select_usb_bus      <= bus.wdata[`BIT_SELECT_USB_BUS];
            o_converter_reference <= bus.wdata[`BIT_CONVERTER_REFERENCE];
            o_emulator_fifo_dir   <= bus.wdata[`BIT_EMULATOR_FIFO_DIR];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            clock_control <= `RST_CLOCK_CONTROL;
        end else if (wr_clock) begin
            clock_control <= bus.wdata;
        end
    end
    assign o_bus_clock_enable = clock_control[`BIT_BUS_CLOCK_ENABLE];
    assign o_deep_halt        = clock_control[`BIT_DEEP_HALT_POWER];

    // Open drain: release for one, pull low for zero, only in aux mode
    assign o_aux_data_pin  = 1'b0;
    assign o_aux_clock_pin = 1'b0;
    assign o_aux_data_oe   = o_select_aux_bus && !aux_data_pin_out;
    assign o_aux_clock_oe  = o_select_aux_bus && !aux_clock_pin_out;

    always_comb begin
        next_rdata = 8'h00;
        unique case (bus.addr)
            `ADDR_BUS_STATUS_CONTROL: begin
                next_rdata[`BIT_BUS_IDLE_FLAG]    = bus_idle_flag;
                next_rdata[`BIT_BUS_RESET_FLAG]   = bus_reset_flag;
                next_rdata[`BIT_WAKE_SEEN_FLAG]   = wake_seen_flag;
                next_rdata[`BIT_AUX_DATA_PIN_IN]  = data_sync[1];
                next_rdata[`BIT_AUX_CLOCK_PIN_IN] = clock_sync[1];
            end
            `ADDR_ENDPOINT_FLAGS_MODE: begin
                next_rdata[3:0]                      = endpoint_flags;
                next_rdata[`BIT_SELECT_AUX_BUS]      = o_select_aux_bus;
                next_rdata[`BIT_SELECT_USB_BUS]      = o_select_usb_bus;
                next_rdata[`BIT_CONVERTER_REFERENCE] = o_converter_reference;
            end
            `ADDR_CLOCK_CONTROL: next_rdata = clock_control;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus.rdata    <= 8'h00;
            bus.usb_irq  <= 1'b0;
            bus.wake_irq <= 1'b0;
        end else begin
            bus.rdata    <= bus.rd ? next_rdata : 8'h00;
            bus.usb_irq  <= (|i_ep_access) || idle_change || reset_rise || wake_set;
            bus.wake_irq <= wake_set;
        end
    end
endmodule // usb_aux_status_dev

// [rtl/usb_aux_status_ctl.sv]
// Purpose: Controller that drives the status block for software
// Assumes: Software uses the plain command port below
// Notes: Keeps shadows of write-only bits for read-modify-write
`timescale 1ns/1ns
`include "usb_aux_status_consts.svh"
module usb_aux_status_ctl
    import usb_aux_status_pkg::*;
#(
    parameter int HOLD_CYCLES = `REMOTE_WAKE_HOLD_CYCLES
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    usb_aux_status_if.ctl   bus,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic [7:0]      o_rdata
);
    ctl_state_t  state;
    logic [7:0]  target;
    logic [7:0]  data;
    logic [1:0]  pin_shadow;
    logic        fifo_shadow;
    logic [1:0]  ep_sel;
    logic        wake_recorded;
    logic        irq_seen;
    logic [15:0] hold_count;
    logic        cmd_go;
    logic [7:0]  ep_keep;

    assign cmd_go  = i_wr && (i_addr == `CTL_ADDR_COMMAND) && (state == ST_IDLE);
    assign ep_keep = ~(8'h01 << ep_sel);

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state      <= ST_IDLE;
            ep_sel     <= 2'h0;
            hold_count <= 16'h0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (cmd_go) begin
                        ep_sel <= i_wdata[`CMD_EP_LSB +: 2];
                        if (i_wdata[`CMD_RAW_WRITE] || i_wdata[`CMD_ARM_DETECT]) begin
                            state <= ST_WRITE;
                        end else if (i_wdata[`CMD_RAW_READ]) begin
                            state <= ST_READ;
                        end else if (i_wdata[`CMD_CLEAR_ENDPOINT]) begin
                            state <= ST_READ;
                        end else if (i_wdata[`CMD_REMOTE_WAKE]) begin
                            state      <= ST_WAKE_HOLD;
                            hold_count <= 16'(HOLD_CYCLES);
                        end
                    end
                end
                ST_WRITE:     state <= ST_IDLE;
                ST_READ:      state <= ST_READ_WAIT;
                // Only a clear command writes back, whatever the target or endpoint
                ST_READ_WAIT: state <= is_ep ? ST_EP_WRITE : ST_IDLE;
                ST_EP_WRITE:  state <= ST_IDLE;
                ST_WAKE_HOLD: begin
                    hold_count <= hold_count - 16'h1;
                    if (hold_count == 16'h1) begin
                        state <= ST_WAKE_RELEASE;
                    end
                end
                ST_WAKE_RELEASE: state <= ST_IDLE;
            endcase
        end
    end

    // Remembers which command kind is running
    logic       is_arm;
    logic       is_ep;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            is_arm <= 1'b0;
            is_ep  <= 1'b0;
        end else if (cmd_go) begin
            is_arm <= i_wdata[`CMD_ARM_DETECT] && !i_wdata[`CMD_RAW_WRITE];
            is_ep  <= i_wdata[`CMD_CLEAR_ENDPOINT] && !i_wdata[`CMD_RAW_READ];
        end
    end

    always_comb begin
        bus.addr  = target;
        bus.wdata = data;
        bus.wr    = 1'b0;
        bus.rd    = 1'b0;
        unique case (state)
            ST_WRITE: begin
                bus.wr = 1'b1;
                if (is_arm) begin
                    bus.addr  = `ADDR_CLOCK_CONTROL;
                    bus.wdata = `CLOCK_CONTROL_ARMED;
                end
            end
            ST_READ: begin
                bus.rd   = 1'b1;
                bus.addr = is_ep ? `ADDR_ENDPOINT_FLAGS_MODE : target;
            end
            ST_EP_WRITE: begin
                bus.wr    = 1'b1;
                bus.addr  = `ADDR_ENDPOINT_FLAGS_MODE;
                bus.wdata = {fifo_shadow, data[6:4], ep_keep[3:0]};
            end
            ST_WAKE_HOLD, ST_WAKE_RELEASE: begin
                bus.wr    = (state == ST_WAKE_RELEASE) || (hold_count == 16'(HOLD_CYCLES));
                bus.addr  = `ADDR_BUS_STATUS_CONTROL;
                bus.wdata = {pin_shadow, 4'h0, state == ST_WAKE_HOLD, 1'b0};
            end
            default: begin
                bus.wr = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            target      <= 8'h00;
            data        <= 8'h00;
            pin_shadow  <= {`RST_AUX_PIN_OUT, `RST_AUX_PIN_OUT};
            fifo_shadow <= `RST_EMULATOR_FIFO_DIR;
        end else begin
            if (i_wr && i_addr == `CTL_ADDR_TARGET && state == ST_IDLE) begin
                target <= i_wdata;
            end
            if (i_wr && i_addr == `CTL_ADDR_DATA && state == ST_IDLE) begin
                data <= i_wdata;
            end else if (state == ST_READ_WAIT) begin
                data <= bus.rdata;
            end
            if (state == ST_WRITE && !is_arm && target == `ADDR_BUS_STATUS_CONTROL) begin
                pin_shadow <= data[7:6];
            end
            if (state == ST_WRITE && !is_arm && target == `ADDR_ENDPOINT_FLAGS_MODE) begin
                fifo_shadow <= data[7];
            end
        end
    end

    // Set wins over a same-cycle software clear
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wake_recorded <= 1'b0;
            irq_seen      <= 1'b0;
        end else begin
            if (bus.wake_irq) begin
                wake_recorded <= 1'b1;
            end else if (i_wr && i_addr == `CTL_ADDR_STATUS && i_wdata[`STAT_WAKE_RECORDED]) begin
                wake_recorded <= 1'b0;
            end
            if (bus.usb_irq) begin
                irq_seen <= 1'b1;
            end else if (i_wr && i_addr == `CTL_ADDR_STATUS && i_wdata[`STAT_IRQ_SEEN]) begin
                irq_seen <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 8'h00;
        end else if (!i_rd) begin
            o_rdata <= 8'h00;
        end else begin
            unique case (i_addr)
                `CTL_ADDR_TARGET: o_rdata <= target;
                `CTL_ADDR_DATA:   o_rdata <= data;
                `CTL_ADDR_STATUS: o_rdata <= {5'h00, irq_seen, wake_recorded, state != ST_IDLE};
                default:          o_rdata <= 8'h00;
            endcase
        end
    end
endmodule // usb_aux_status_ctl

// [verification/usb_aux_status_properties.sv]
// Purpose: Interface checks between the controller and the status block
// Assumes: One clock; read data stands only in the cycle after a read strobe
// Notes: Remote wake hold is counted in helper logic
`timescale 1ns/1ns
module usb_aux_status_properties #(
    parameter int HOLD_CYCLES = 10
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic [7:0] rdata,
    input  wire logic       usb_irq,
    input  wire logic       wake_irq
);
    logic        wake_on;
    logic [15:0] wake_cnt;
    wire         set_wake = wr && addr == 8'h1A && wdata[1];
    wire         clr_wake = wr && addr == 8'h1A && !wdata[1];

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wake_on <= 1'b0;
        end else if (set_wake || clr_wake) begin
            wake_on <= set_wake;
        end
    end

    // Saturates so a long hold never wraps
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wake_cnt <= 16'h0000;
        end else if (set_wake) begin
            wake_cnt <= 16'h0000;
        end else if (wake_cnt != 16'hFFFF) begin
            wake_cnt <= wake_cnt + 16'h0001;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    AST_ONE_STROBE: assert property (!(wr && rd))
        else $error("write and read strobes together");
    AST_RDATA_REST: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside its slot");
    AST_STATUS_WO_ZERO: assert property (rd && addr == 8'h1A |=> (rdata & 8'hC2) == 8'h00)
        else $error("write-only status bits read back");
    AST_FIFO_DIR_ZERO: assert property (rd && addr == 8'h1B |=> !rdata[7])
        else $error("fifo direction bit read back");
    AST_UNMAPPED_ZERO: assert property (rd && (addr < 8'h1A || addr > 8'h1C) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_WAKE_IRQ_ORED: assert property (wake_irq |-> usb_irq)
        else $error("wake event without usb interrupt");
    AST_WAKE_IRQ_PULSE: assert property (wake_irq |=> !wake_irq)
        else $error("wake interrupt longer than one cycle");
    AST_WAKE_HOLD: assert property (clr_wake && wake_on |-> wake_cnt + 16'h0001 >= 16'(HOLD_CYCLES))
        else $error("remote wake released too early");
    AST_WAKE_RELEASE: assert property (set_wake |-> ##[1:60] clr_wake)
        else $error("remote wake never released");
endmodule // usb_aux_status_properties

// [verification/usb_ps2_status_and_endpoint_flags_bench.sv]
// Purpose: Software port and engine event stimulus for both ends
// Assumes: Hold counts shortened for simulation
// Notes: Read results are checked against a queue of notes
`timescale 1ns/1ns
module usb_ps2_status_and_endpoint_flags_bench;
    localparam int WAKE_HOLD = 50;
    localparam int HOLD      = 10;
    typedef struct packed {
        logic [7:0] exp;
        logic [7:0] mask;
    } note_t;
    logic       clk_sys;
    logic       rst_b     = 1'b0;
    logic [3:0] sw_addr   = 4'h0;
    logic [7:0] sw_wdata  = 8'h00;
    logic       sw_wr     = 1'b0;
    logic       sw_rd     = 1'b0;
    logic [7:0] sw_rdata;
    logic [7:0] last;
    logic [7:0] m;
    logic       suspend   = 1'b0;
    logic       bus_reset = 1'b0;
    logic       resume    = 1'b0;
    logic [3:0] ep_access = 4'h0;
    logic       data_drv  = 1'b1;
    logic       clk_drv   = 1'b1;
    logic       rd_seen   = 1'b0;
    logic       remote_wake;
    logic       data_out;
    logic       clk_out;
    wire  [7:0] outs;
    note_t      cur;
    note_t      notes[$];
    int         miscompares = 0;
    int         samples_checked = 0;
    int         n;
    // Open drain: a driving end pulls the wire low
    wire        data_lvl = outs[1] ? data_out : data_drv;
    wire        clk_lvl  = outs[0] ? clk_out : clk_drv;

    usb_aux_status_if bus_if ();
    usb_aux_status_dev #(.WAKE_HOLD_CYCLES(WAKE_HOLD)) usb_aux_status_dev_inst (
        .i_clk_sys(clk_sys), .i_rst_b(rst_b), .bus(bus_if),
        .i_sie_suspend(suspend), .i_sie_bus_reset(bus_reset), .i_sie_resume(resume),
        .i_ep_access(ep_access), .i_aux_data_pin(data_lvl), .i_aux_clock_pin(clk_lvl),
        .o_aux_data_pin(data_out), .o_aux_data_oe(outs[1]), .o_aux_clock_pin(clk_out),
        .o_aux_clock_oe(outs[0]), .o_remote_wake(remote_wake), .o_select_aux_bus(outs[7]),
        .o_select_usb_bus(outs[6]), .o_converter_reference(outs[5]),
        .o_emulator_fifo_dir(outs[4]), .o_bus_clock_enable(outs[3]), .o_deep_halt(outs[2]));
    usb_aux_status_ctl #(.HOLD_CYCLES(HOLD)) usb_aux_status_ctl_inst (
        .i_clk_sys(clk_sys), .i_rst_b(rst_b), .bus(bus_if), .i_addr(sw_addr),
        .i_wdata(sw_wdata), .i_wr(sw_wr), .i_rd(sw_rd), .o_rdata(sw_rdata));
    usb_aux_status_properties #(.HOLD_CYCLES(HOLD)) usb_aux_status_properties_inst (
        .i_clk_sys(clk_sys), .i_rst_b(rst_b), .addr(bus_if.addr), .wdata(bus_if.wdata),
        .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata), .usb_irq(bus_if.usb_irq),
        .wake_irq(bus_if.wake_irq));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Read data stands one cycle only, so the watcher samples it right then
    always @(posedge clk_sys) begin
        if (rd_seen && notes.size() > 0) begin
            cur = notes.pop_front();
            if (cur.mask != 8'h00) begin
                check(sw_rdata & cur.mask, cur.exp & cur.mask);
            end
        end
        rd_seen <= sw_rd;
    end

    task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk_sys);
        sw_wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic sw_read(input logic [3:0] a, input logic [7:0] e, input logic [7:0] k);
        sw_addr <= a;
        sw_rd <= 1'b1;
        notes.push_back('{e, k});
        @(posedge clk_sys);
        sw_rd <= 1'b0;
        #1 last = sw_rdata;
        @(posedge clk_sys);
    endtask

    task automatic wait_idle;
        int i;
        i = 0;
        do begin
            sw_read(4'h3, 8'h00, 8'h00);
            i++;
        end while (last[0] !== 1'b0 && i < 400);
        check({7'h00, last[0]}, 8'h00);
    endtask

    task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
        sw_write(4'h1, a);
        sw_write(4'h2, d);
        sw_write(4'h0, 8'h01);
        wait_idle();
    endtask

    task automatic dev_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] k);
        sw_write(4'h1, a);
        sw_write(4'h0, 8'h02);
        wait_idle();
        sw_read(4'h2, e, k);
    endtask

    // Ends one-cycle event pulses and looks at the interrupt slot
    task automatic irq_chk(input logic [1:0] e);
        @(posedge clk_sys);
        resume <= 1'b0;
        ep_access <= 4'h0;
        #1 check({6'h00, bus_if.usb_irq, bus_if.wake_irq}, {6'h00, e});
        @(posedge clk_sys);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        finish_test();
    end

    initial begin
        void'($urandom(32'h432ada5d));
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        check(outs, 8'h20);
        check({7'h00, remote_wake}, 8'h00);
        m = 8'($urandom);
        data_drv <= m[0];
        clk_drv <= m[1];
        dev_rd(8'h1A, {2'b00, m[1], m[0], 4'h0}, 8'hFF);
        repeat (4) begin
            m = 8'($urandom);
            dev_wr(8'h1B, {m[7:4], 4'hF});
            check(outs, {m[4], m[5], m[6], m[7], 4'h0});
            dev_rd(8'h1B, {1'b0, m[6:4], 4'h0}, 8'hFF);
        end
        dev_wr(8'h1B, 8'h5F);
        dev_wr(8'h1A, 8'h80);
        check(outs, 8'hA2);
        dev_rd(8'h1A, {2'b00, m[1], 1'b0, 4'h0}, 8'hFF);
        dev_wr(8'h1A, 8'hC0);
        for (n = 0; n < 4; n++) begin
            ep_access <= 4'(1 << n);
            irq_chk(2'b10);
            sw_read(4'h3, 8'h04, 8'h04);
            sw_write(4'h3, 8'h06);
            dev_wr(8'h1B, 8'h5F);
            dev_rd(8'h1B, 8'h50 | 8'(1 << n), 8'hFF);
            if (n == 0) begin
                dev_wr(8'h1B, 8'h5E);
            end else begin
                sw_write(4'h0, {1'b0, 2'(n), 5'h10});
                wait_idle();
            end
            dev_rd(8'h1B, 8'h50, 8'hFF);
        end
        bus_reset <= 1'b1;
        irq_chk(2'b10);
        dev_wr(8'h1A, 8'hC0);
        dev_rd(8'h1A, 8'h04, 8'h0F);
        bus_reset <= 1'b0;
        irq_chk(2'b00);
        sw_write(4'h0, 8'h04);
        wait_idle();
        check(outs, 8'hA8);
        suspend <= 1'b1;
        irq_chk(2'b10);
        dev_rd(8'h1A, 8'h01, 8'h0F);
        resume <= 1'b1;
        irq_chk(2'b11);
        sw_read(4'h3, 8'h02, 8'h02);
        suspend <= 1'b0;
        irq_chk(2'b10);
        dev_rd(8'h1A, 8'h08, 8'h0F);
        repeat (WAKE_HOLD) @(posedge clk_sys);
        dev_rd(8'h1A, 8'h00, 8'h0F);
        resume <= 1'b1;
        irq_chk(2'b00);
        sw_write(4'h0, 8'h08);
        n = 0;
        repeat (HOLD * 4) begin
            @(posedge clk_sys);
            if (remote_wake === 1'b1) n++;
        end
        check({7'h00, n >= HOLD}, 8'h01);
        wait_idle();
        check({7'h00, remote_wake}, 8'h00);
        dev_wr(8'h30, 8'hFF);
        dev_rd(8'h30, 8'h00, 8'hFF);
        rst_b <= 1'b0;
        @(posedge clk_sys);
        check(outs, 8'h20);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        finish_test();
    end
endmodule // usb_ps2_status_and_endpoint_flags_bench
